// ==== include/ebc_pkg.sv ====
// Constants, configuration structs and states of the external bus controller
package ebc_pkg;
    // Bus geometry
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int LO_W = 16;
    localparam int SEG_W = 8;
    localparam int NUM_WIN = 4;
    localparam int SEL_W = 3;
    localparam int CNT_W = 4;
    localparam int BASE_W = 12;
    localparam int SIZE_W = 4;
    localparam int LINES_W = 5;
    // Reference clock timing
    localparam int SYS_PERIOD_NS = 10;
    localparam int REF_PERIOD_NS = 20;
    localparam int REF_HALF_CYC =
        (REF_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int DIV_W = 4;
    // Segment that holds the on-chip peripheral bus
    localparam logic [SEG_W-1:0] PBUS_SEG = 8'h20;
    // Handy fill values
    localparam logic [ADDR_W-1:0] ADDR_ONES = 24'hffffff;
    localparam logic [BASE_W-1:0] BASE_ONES = 12'hfff;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // Per-region bus timing, counted in reference clock periods
    typedef struct packed {
        logic [CNT_W-1:0] addr_cyc;
        logic [CNT_W-1:0] wait_cyc;
        logic [CNT_W-1:0] hold_cyc;
    } tcfg_s;

    // Per-region bus mode
    typedef struct packed {
        logic bus16;
        logic mux;
        logic rdy_en;
        logic rdy_pol;
    } fcfg_s;

    // Address window: base on A23..A12, size = ignored low base bits
    typedef struct packed {
        logic enable;
        logic [BASE_W-1:0] base;
        logic [SIZE_W-1:0] size;
    } wsel_s;

    // Access request from the program and data units
    typedef struct packed {
        logic valid;
        logic we;
        logic word;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_s;

    typedef enum {ST_IDLE, ST_EDGE, ST_ADDR, ST_DATA, ST_HOLD, ST_PBUS}
        state_e;
endpackage

// ==== design/bit_sync.sv ====
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/100ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by second stage
    logic [WIDTH-1:0] sync_q;

    // Both stages clear to zero under reset
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ==== design/window_match.sv ====
// Compares an address against one address window
`timescale 1ns/100ps
module window_match
    import ebc_pkg::*;
(
    input wire logic [ebc_pkg::BASE_W-1:0] addr_hi_i,
    input ebc_pkg::wsel_s wsel_i,
    output logic hit_o
);
    logic [BASE_W-1:0] keep; // Base bits that take part in the compare

    // Low bits given by size are ignored, the rest must equal the base
    always_comb begin
        keep = BASE_ONES << wsel_i.size;
        hit_o = wsel_i.enable &&
            (((addr_hi_i ^ wsel_i.base) & keep) == '0);
    end
endmodule

// ==== design/ext_bus_controller.sv ====
// External bus controller: windows, chip selects, bus phases, peripheral bus
//
// Functional notes
// - Single-chip mode refuses external accesses.
// - Address output width selectable zero to 24.
// - Eight or sixteen bit external data bus.
// - Multiplexed or demultiplexed address and data.
// - Demux drives low address on separate lines.
// - Active segment lines selectable, shrinking space.
// - Deselected segment lines are not driven.
// - One active-low select per window plus default.
// - Timing and mode programmable per region.
// - Ready input with selectable active level.
// - Four windows, higher number wins on overlap.
// - Uncovered addresses use default region settings.
// - Only the selected region asserts its select.
// - Bus timing follows reference clock rising edge.
// - Width and multiplexing switch per access.
// - Peripheral bus accesses stay on chip, no select asserted.
// - Reserved areas become ordinary external accesses.
`timescale 1ns/100ps
module ext_bus_controller #(
    parameter int NUM_WIN = ebc_pkg::NUM_WIN
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Configuration
    input wire logic ext_mode_i,
    input wire logic [ebc_pkg::LINES_W-1:0] addr_lines_i,
    input ebc_pkg::tcfg_s [NUM_WIN-1:0] window_timing_config_i,
    input ebc_pkg::fcfg_s [NUM_WIN-1:0] window_function_config_i,
    input ebc_pkg::wsel_s [NUM_WIN-1:0] window_address_select_i,
    input ebc_pkg::tcfg_s default_timing_config_i,
    input ebc_pkg::fcfg_s default_function_config_i,
    // Request side
    input ebc_pkg::req_s req_i,
    output logic busy_o,
    output logic ack_o,
    output logic err_o,
    output logic [ebc_pkg::DATA_W-1:0] rdata_o,
    // On-chip peripheral bus
    output logic pbus_req_o,
    output logic pbus_we_o,
    output logic [ebc_pkg::ADDR_W-1:0] pbus_addr_o,
    output logic [ebc_pkg::DATA_W-1:0] pbus_wdata_o,
    input wire logic [ebc_pkg::DATA_W-1:0] pbus_rdata_i,
    input wire logic pbus_ack_i,
    // External bus pins
    output logic bus_reference_clock_out_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [NUM_WIN:0] cs_n_o,
    output logic [ebc_pkg::DATA_W-1:0] ad_o,
    output logic ad_oe_o,
    input wire logic [ebc_pkg::DATA_W-1:0] ad_i,
    output logic [ebc_pkg::LO_W-1:0] addr_lo_o,
    output logic [ebc_pkg::LO_W-1:0] addr_lo_oe_o,
    output logic [ebc_pkg::SEG_W-1:0] seg_addr_o,
    output logic [ebc_pkg::SEG_W-1:0] seg_oe_o,
    input wire logic ready_i
);
    import ebc_pkg::*;

    // Refuse window counts the select index cannot encode
    if (NUM_WIN < 1 || NUM_WIN >= (1 << SEL_W)) begin : g_chk
        $error("NUM_WIN out of range");
    end

    // Divider state
    logic [DIV_W-1:0] div_q, div_d;
    logic ref_q, ref_d;
    logic ref_rise; // Reference clock rises at the next edge

    // Access state
    state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d; // Phase length counter
    req_s cur_q, cur_d; // Latched access
    logic [SEL_W-1:0] sel_q, sel_d; // Region: 0 default, i+1 window
    logic hi_q, hi_d; // Second byte of a split word
    logic busy_q, busy_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic pbus_req_q, pbus_req_d;
    logic cap_q, cap_d; // Read data is due from the pin synchroniser

    // Pin registers
    logic ale_q, ale_d;
    logic rd_n_q, rd_n_d;
    logic wr_n_q, wr_n_d;
    logic [NUM_WIN:0] cs_n_q, cs_n_d;
    logic [DATA_W-1:0] ad_q, ad_d;
    logic ad_oe_q, ad_oe_d;
    logic [LO_W-1:0] lo_q, lo_d;
    logic [LO_W-1:0] lo_oe_q, lo_oe_d;
    logic [SEG_W-1:0] seg_q, seg_d;
    logic [SEG_W-1:0] seg_oe_q, seg_oe_d;

    // Decode helpers
    logic [NUM_WIN-1:0] hit; // Window hits for the incoming address
    logic [SEL_W-1:0] win_sel; // Prioritised region of the request
    logic pbus_hit;
    tcfg_s all_t [NUM_WIN+1];
    fcfg_s all_f [NUM_WIN+1];
    tcfg_s t_cfg; // Timing of the running access
    fcfg_s f_cfg; // Mode of the running access
    fcfg_s f_nxt; // Mode of the access after this edge
    logic split; // Word access on an eight-bit bus
    logic rdy_ok;
    logic [ADDR_W-1:0] amask; // Enabled address lines
    logic [ADDR_W-1:0] baddr; // Address placed on the pins
    logic [DATA_W-1:0] wlane; // Write data placed on the pins
    logic [DATA_W:0] pin_sync; // Synchronised {ready, data}
    logic [DATA_W-1:0] ad_sync;
    logic rdy_sync;

    // Pin inputs pass two flops before use
    bit_sync #(.WIDTH(DATA_W + 1)) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i({ready_i, ad_i}),
        .sync_o(pin_sync)
    );
    assign ad_sync = pin_sync[DATA_W-1:0];
    assign rdy_sync = pin_sync[DATA_W];

    // One comparator per window
    for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
        window_match u_match (
            .addr_hi_i(req_i.addr[ADDR_W-1 -: BASE_W]),
            .wsel_i(window_address_select_i[i]),
            .hit_o(hit[i])
        );
    end

    // Region table, index 0 is the default region
    always_comb begin
        all_t[0] = default_timing_config_i;
        all_f[0] = default_function_config_i;
        for (int i = 0; i < NUM_WIN; i++) begin
            all_t[i+1] = window_timing_config_i[i];
            all_f[i+1] = window_function_config_i[i];
        end
    end

    // Highest numbered hitting window wins, none hit means default
    always_comb begin
        win_sel = '0;
        for (int i = 0; i < NUM_WIN; i++) begin
            if (hit[i]) begin
                win_sel = SEL_W'(i + 1);
            end
        end
    end

    // Only the peripheral segment stays inside; reserved areas go out
    assign pbus_hit = (req_i.addr[ADDR_W-1 -: SEG_W] == PBUS_SEG);

    // Reference clock divider, next and registered values
    always_comb begin
        ref_d = ref_q;
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_W'(REF_HALF_CYC - 1)) begin
            div_d = '0;
            ref_d = !ref_q;
        end
        ref_rise = !ref_q && (div_q == DIV_W'(REF_HALF_CYC - 1));
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            div_q <= '0;
            ref_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ref_q <= ref_d;
        end
    end

    // Settings of the running access
    assign t_cfg = all_t[sel_q];
    assign f_cfg = all_f[sel_q];
    assign split = !f_cfg.bus16 && cur_q.word;
    assign rdy_ok = !f_cfg.rdy_en || (rdy_sync == f_cfg.rdy_pol);

    // Access sequencer and pin values
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        sel_d = sel_q;
        hi_d = hi_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        pbus_req_d = pbus_req_q;
        cap_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Take a new request and pick its region
                if (req_i.valid) begin
                    cur_d = req_i;
                    sel_d = win_sel;
                    hi_d = 1'b0;
                    if (pbus_hit) begin
                        state_d = ST_PBUS;
                        pbus_req_d = 1'b1;
                    end else if (!ext_mode_i) begin
                        ack_d = 1'b1;
                        err_d = 1'b1;
                        rdata_d = '0;
                    end else begin
                        state_d = ST_EDGE;
                    end
                end
            end
            ST_EDGE: begin
                // Wait for a reference clock rising edge
                if (ref_rise) begin
                    state_d = ST_ADDR;
                    cnt_d = t_cfg.addr_cyc;
                end
            end
            ST_ADDR: begin
                // Address phase
                if (ref_rise) begin
                    if (cnt_q == CNT_ZERO) begin
                        state_d = ST_DATA;
                        cnt_d = t_cfg.wait_cyc;
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
            end
            ST_DATA: begin
                // Programmed waits, then ready decides
                if (ref_rise) begin
                    if (cnt_q != CNT_ZERO) begin
                        cnt_d = cnt_q - CNT_ONE;
                    end else if (rdy_ok) begin
                        state_d = ST_HOLD;
                        cnt_d = t_cfg.hold_cyc;
                        cap_d = !cur_q.we;
                    end
                end
            end
            ST_HOLD: begin
                // Synchronised pins lag two edges, so the strobe data
                // is only visible one edge after the data phase ends
                if (cap_q) begin
                    if (!f_cfg.bus16) begin
                        rdata_d = hi_q ?
                            {ad_sync[7:0], rdata_q[7:0]} :
                            {8'h00, ad_sync[7:0]};
                    end else if (cur_q.word) begin
                        rdata_d = ad_sync;
                    end else begin
                        rdata_d = cur_q.addr[0] ?
                            {8'h00, ad_sync[15:8]} :
                            {8'h00, ad_sync[7:0]};
                    end
                end
                // Hold phase, then second byte or finish
                if (ref_rise) begin
                    if (cnt_q != CNT_ZERO) begin
                        cnt_d = cnt_q - CNT_ONE;
                    end else if (split && !hi_q) begin
                        hi_d = 1'b1;
                        state_d = ST_ADDR;
                        cnt_d = t_cfg.addr_cyc;
                    end else begin
                        state_d = ST_IDLE;
                        ack_d = 1'b1;
                    end
                end
            end
            ST_PBUS: begin
                // Peripheral bus holds the request until it answers
                if (pbus_ack_i) begin
                    pbus_req_d = 1'b0;
                    rdata_d = pbus_rdata_i;
                    ack_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d != ST_IDLE);

        // Pin values that go with the next state
        f_nxt = all_f[sel_d];
        amask = ~(ADDR_ONES << addr_lines_i);
        baddr = {cur_d.addr[ADDR_W-1:1], cur_d.addr[0] | hi_d};
        if (!f_nxt.bus16) begin
            wlane = hi_d ? {8'h00, cur_d.wdata[15:8]} :
                {8'h00, cur_d.wdata[7:0]};
        end else if (cur_d.word) begin
            wlane = cur_d.wdata;
        end else begin
            wlane = {cur_d.wdata[7:0], cur_d.wdata[7:0]};
        end
        cs_n_d = '1;
        ale_d = 1'b0;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        ad_d = '0;
        ad_oe_d = 1'b0;
        lo_d = '0;
        lo_oe_d = '0;
        seg_d = '0;
        seg_oe_d = '0;
        if (state_d == ST_ADDR || state_d == ST_DATA ||
                state_d == ST_HOLD) begin
            cs_n_d[sel_d] = 1'b0;
            seg_d = baddr[ADDR_W-1 -: SEG_W] & amask[ADDR_W-1 -: SEG_W];
            seg_oe_d = amask[ADDR_W-1 -: SEG_W];
            if (!f_nxt.mux) begin
                lo_d = baddr[LO_W-1:0] & amask[LO_W-1:0];
                lo_oe_d = amask[LO_W-1:0];
            end
        end
        if (state_d == ST_ADDR) begin
            ale_d = 1'b1;
            if (f_nxt.mux) begin
                ad_d = baddr[LO_W-1:0] & amask[LO_W-1:0];
                ad_oe_d = 1'b1;
            end
        end else if (state_d == ST_DATA || state_d == ST_HOLD) begin
            ad_d = cur_d.we ? wlane : '0;
            ad_oe_d = cur_d.we;
            rd_n_d = !(state_d == ST_DATA && !cur_d.we);
            wr_n_d = !(state_d == ST_DATA && cur_d.we);
        end
    end

    // Registers of the sequencer and the pins
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            cur_q <= '0;
            sel_q <= '0;
            hi_q <= 1'b0;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
            pbus_req_q <= 1'b0;
            cap_q <= 1'b0;
            ale_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            cs_n_q <= '1;
            ad_q <= '0;
            ad_oe_q <= 1'b0;
            lo_q <= '0;
            lo_oe_q <= '0;
            seg_q <= '0;
            seg_oe_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
            sel_q <= sel_d;
            hi_q <= hi_d;
            busy_q <= busy_d;
            ack_q <= ack_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
            pbus_req_q <= pbus_req_d;
            cap_q <= cap_d;
            ale_q <= ale_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            cs_n_q <= cs_n_d;
            ad_q <= ad_d;
            ad_oe_q <= ad_oe_d;
            lo_q <= lo_d;
            lo_oe_q <= lo_oe_d;
            seg_q <= seg_d;
            seg_oe_q <= seg_oe_d;
        end
    end

    // Outputs straight from flops
    assign busy_o = busy_q;
    assign ack_o = ack_q;
    assign err_o = err_q;
    assign rdata_o = rdata_q;
    assign pbus_req_o = pbus_req_q;
    assign pbus_we_o = cur_q.we;
    assign pbus_addr_o = cur_q.addr;
    assign pbus_wdata_o = cur_q.wdata;
    assign bus_reference_clock_out_o = ref_q;
    assign ale_o = ale_q;
    assign rd_n_o = rd_n_q;
    assign wr_n_o = wr_n_q;
    assign cs_n_o = cs_n_q;
    assign ad_o = ad_q;
    assign ad_oe_o = ad_oe_q;
    assign addr_lo_o = lo_q;
    assign addr_lo_oe_o = lo_oe_q;
    assign seg_addr_o = seg_q;
    assign seg_oe_o = seg_oe_q;

    // Checks on the sequencer
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    logic take_ext; // External request taken this cycle
    assign take_ext = (state_q == ST_IDLE) && req_i.valid && !pbus_hit;

    single_chip_a: assert property (take_ext && !ext_mode_i
        |=> ack_o && err_o && cs_n_o == '1)
        else $error("single-chip access not refused");
    cs_onehot_a: assert property ($onehot0(~cs_n_o))
        else $error("more than one select active");
    window_prio_a: assert property (take_ext && ext_mode_i &&
        hit[NUM_WIN-1] |=> sel_q == SEL_W'(NUM_WIN))
        else $error("top window did not win");
    default_rgn_a: assert property (take_ext && ext_mode_i &&
        hit == '0 |=> sel_q == '0 ##[1:4] !cs_n_o[0])
        else $error("default region not used");
    ref_edge_a: assert property ($rose(ale_o)
        |-> $rose(bus_reference_clock_out_o))
        else $error("address phase off reference edge");
    ready_wait_a: assert property (state_q == ST_DATA &&
        cnt_q == '0 && ref_rise && !rdy_ok
        |=> state_q == ST_DATA && !cs_n_o[sel_q])
        else $error("access ended without ready");
    mux_read_a: assert property (!rd_n_o && f_cfg.mux |-> !ad_oe_o)
        else $error("mux read drives shared lines");
    demux_addr_a: assert property (!rd_n_o && !f_cfg.mux
        |-> addr_lo_o == ((cur_q.addr[LO_W-1:0] | LO_W'(hi_q)) &
        amask[LO_W-1:0]))
        else $error("demux low address missing");
    seg_free_a: assert property ($stable(addr_lines_i) && ale_o
        |-> (seg_oe_o & ~amask[ADDR_W-1 -: SEG_W]) == '0)
        else $error("deselected segment line driven");
    pbus_ack_a: assert property (pbus_req_o && pbus_ack_i
        |=> ack_o && !pbus_req_o)
        else $error("peripheral answer not passed on");

    ready_wait_c: cover property (state_q == ST_DATA && ref_rise &&
        cnt_q == '0 && !rdy_ok);
    split_word_c: cover property (hi_q && state_q == ST_ADDR);
    pbus_c: cover property (pbus_req_o && pbus_ack_i);
    mux_write_c: cover property (!wr_n_o && f_cfg.mux);
endmodule

// ==== tb/ext_mem_model.sv ====
// Memory model on the shared external bus, with a ready output
`timescale 1ns/100ps
module ext_mem_model (
    input wire logic clk_sys_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [4:0] cs_n_i,
    input wire logic [15:0] ad_i,
    input wire logic [15:0] addr_lo_i,
    input wire logic addr_lo_oe_i,
    input wire logic bus16_i,
    input wire logic rdy_pol_i,
    input wire logic [3:0] slow_i,
    output logic [15:0] ad_o,
    output logic ready_o
);
    logic [7:0] mem_q [256]; // Byte store
    logic [7:0] a_q; // Latched address
    logic [3:0] cnt_q = 4'h0; // Cycles into the strobe
    logic [15:0] last_q = 16'h0; // Last value driven
    logic sel; // Some select active
    assign sel = ~&cs_n_i;
    // Latch the address, store writes, time the strobe
    always_ff @(posedge clk_sys_i) begin
        if (ale_i) begin
            a_q <= addr_lo_oe_i ? addr_lo_i[7:0] : ad_i[7:0];
        end
        cnt_q <= (rd_n_i & wr_n_i) ? 4'h0 : cnt_q + 4'h1;
        if (sel && !wr_n_i) begin
            mem_q[a_q] <= ad_i[7:0];
            if (bus16_i) begin
                mem_q[a_q | 8'h01] <= ad_i[15:8];
            end
        end
        if (sel && !rd_n_i) begin
            last_q <= ad_o;
        end
    end
    // Drive data only while selected and read; otherwise scramble
    always_comb begin
        ad_o = ~last_q;
        if (sel && !rd_n_i) begin
            ad_o = bus16_i ? {mem_q[a_q | 8'h01], mem_q[a_q & 8'hfe]}
                           : {~last_q[15:8], mem_q[a_q]};
        end
    end
    // Ready turns active after slow_i strobe cycles
    assign ready_o = (cnt_q >= slow_i) ? rdy_pol_i : ~rdy_pol_i;
endmodule

// ==== tb/testbench.sv ====
// Testbench of the external bus controller with a memory model
`timescale 1ns/100ps
module testbench;
    import ebc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ext_mode_i = 1'b0; // Single-chip first
    logic [LINES_W-1:0] addr_lines_i = 5'h18;
    tcfg_s [NUM_WIN-1:0] wt = {12'h0, 12'h0, 12'h0, 12'h121};
    fcfg_s [NUM_WIN-1:0] wf = 16'hec03;
    wsel_s [NUM_WIN-1:0] ws = {17'h1_5004, 17'h1_5004, 17'h0, 17'h1_4004};
    tcfg_s dt = '0;
    fcfg_s df = 4'hc; // 16-bit, multiplexed
    req_s req = '0;
    logic busy, ack, err, pbus_req, pbus_we, refclk, ale, rd_n, wr_n;
    logic ad_oe, ready, m16, mpol, pbus_ack = 1'b0;
    logic [3:0] mslow = 4'h0;
    logic [4:0] cs_n, cs_and;
    logic [7:0] seg, seg_oe, seg_or, sg;
    logic [16:0] pw; // Write flag and data seen on the peripheral bus
    logic [15:0] rdata, pbus_wdata, ad_o, ad_i, lo, lo_oe;
    logic [23:0] pbus_addr, pa;
    logic lo_or, ale_p = 1'b0, ref_p = 1'b0;
    int n_errors = 0, num_checks = 0, bad = 0, cyc = 0, cyc_d, clash = 0;

    ext_bus_controller i_ext_bus_controller (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .ext_mode_i(ext_mode_i),
        .addr_lines_i(addr_lines_i), .window_timing_config_i(wt),
        .window_function_config_i(wf), .window_address_select_i(ws),
        .default_timing_config_i(dt), .default_function_config_i(df),
        .req_i(req), .busy_o(busy), .ack_o(ack), .err_o(err),
        .rdata_o(rdata), .pbus_req_o(pbus_req), .pbus_we_o(pbus_we),
        .pbus_addr_o(pbus_addr), .pbus_wdata_o(pbus_wdata),
        .pbus_rdata_i(16'h5a3c), .pbus_ack_i(pbus_ack),
        .bus_reference_clock_out_o(refclk), .ale_o(ale), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .cs_n_o(cs_n), .ad_o(ad_o), .ad_oe_o(ad_oe),
        .ad_i(ad_i), .addr_lo_o(lo), .addr_lo_oe_o(lo_oe),
        .seg_addr_o(seg), .seg_oe_o(seg_oe), .ready_i(ready));

    ext_mem_model i_ext_mem_model (.clk_sys_i(clk_sys_i), .ale_i(ale),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n), .ad_i(ad_o),
        .addr_lo_i(lo), .addr_lo_oe_i(lo_oe[0]), .bus16_i(m16),
        .rdy_pol_i(mpol), .slow_i(mslow), .ad_o(ad_i), .ready_o(ready));

    // Clock of 10 ns
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Peripheral bus answers one cycle after a request
    always @(posedge clk_sys_i) begin
        pbus_ack <= #1 pbus_req && !pbus_ack;
        if (pbus_req) begin
            pa = pbus_addr;
            pw = {pbus_we, pbus_wdata};
        end
    end

    // Pin monitor; address phase must start on a reference rise
    always @(posedge clk_sys_i) begin
        cs_and = cs_and & cs_n;
        seg_or = seg_or | seg_oe;
        lo_or = lo_or | lo_oe[0];
        // Segment value of the address phase; read clash or busy at done
        if (ale) begin
            sg = seg;
        end
        if ((!rd_n && ad_oe) || (ack && busy)) begin
            clash++;
        end
        if (ale && !ale_p && !(refclk && !ref_p)) begin
            bad++;
        end
        ale_p = ale;
        ref_p = refclk;
    end

    // Comparison of a seen value with the expected one
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts and verdict
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One access: pulse valid, then wait for the done pulse
    task automatic acc(input logic we, input logic [23:0] a,
                       input logic [15:0] wd);
        @(posedge clk_sys_i);
        #1;
        req = {1'b1, we, 1'b1, a, wd};
        cs_and = 5'h1f;
        seg_or = 8'h0;
        lo_or = 1'b0;
        cyc = 0;
        @(posedge clk_sys_i);
        #1;
        req.valid = 1'b0;
        while (ack !== 1'b1 && cyc < 200) begin
            @(posedge clk_sys_i);
            #1;
            cyc++;
        end
        if (cyc >= 200) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // Main sequence
    initial begin
        m16 = 1'b1;
        mpol = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        acc(1'b1, 24'h001234, 16'hbeef);
        chk(err, 1'b1);
        chk(cs_and, 5'h1f);
        ext_mode_i = 1'b1;
        acc(1'b1, 24'h001234, 16'hbeef);
        chk(cs_and, 5'h1e);
        chk(seg_or, 8'hff);
        acc(1'b0, 24'h001234, 16'h0);
        cyc_d = cyc;
        chk(rdata, 16'hbeef);
        m16 = 1'b0;
        mslow = 4'h6;
        acc(1'b1, 24'h400010, 16'ha55a);
        chk(cs_and, 5'h1d);
        chk(lo_or, 1'b1);
        chk(sg, 8'h40);
        acc(1'b0, 24'h400010, 16'h0);
        chk(rdata, 16'ha55a);
        chk(cyc > cyc_d, 1'b1);
        m16 = 1'b1;
        mpol = 1'b0;
        mslow = 4'h2;
        acc(1'b1, 24'h500020, 16'h1357);
        chk(cs_and, 5'h0f);
        acc(1'b0, 24'h500020, 16'h0);
        chk(rdata, 16'h1357);
        mpol = 1'b1;
        mslow = 4'h0;
        acc(1'b1, 24'he08002, 16'h2468);
        chk(cs_and, 5'h1e);
        acc(1'b0, 24'he08002, 16'h0);
        chk(rdata, 16'h2468);
        acc(1'b0, 24'h204000, 16'h0);
        chk(rdata, 16'h5a3c);
        chk(pa, 24'h204000);
        chk(cs_and, 5'h1f);
        chk(pw[16], 1'b0);
        acc(1'b1, 24'h204000, 16'h1122);
        chk(pw, 17'h11122);
        addr_lines_i = 5'h10;
        acc(1'b0, 24'h001234, 16'h0);
        chk(seg_or, 8'h00);
        chk(sg, 8'h00);
        chk(clash, 0);
        chk(rdata, 16'hbeef);
        chk(bad, 0);
        end_of_test();
    end
endmodule
